// >>> clkrng_pkg.sv
package clkrng_pkg;
  localparam int unsigned   CLKRNG_ADDR_W           = 15;
  localparam int unsigned   CLKRNG_POS_W            = 24;
  localparam int unsigned   CLKRNG_FS_W             = 16;
  localparam int unsigned   CLKRNG_DSEL_W           = 4;
  // byte offsets
  localparam logic [14:0]   CLKRNG_OFS_CLK_CTRL     = 15'h002a;
  localparam logic [14:0]   CLKRNG_OFS_SUPPLY       = 15'h002b;
  localparam logic [14:0]   CLKRNG_OFS_EDGE_POS     = 15'h002c;
  localparam logic [14:0]   CLKRNG_OFS_FULLSCALE    = 15'h0030;
  // reset values
  localparam logic [7:0]    CLKRNG_RST_CLK_CTRL     = 8'h00;
  localparam logic [7:0]    CLKRNG_RST_SUPPLY       = 8'h10;
  localparam logic [23:0]   CLKRNG_RST_EDGE_POS     = 24'h000000;
  localparam logic [15:0]   CLKRNG_RST_FULLSCALE    = 16'ha000;
  // field positions
  localparam int unsigned   CLKRNG_BIT_INVERT       = 0;
  localparam int unsigned   CLKRNG_BIT_REF_PECL     = 1;
  localparam int unsigned   CLKRNG_BIT_DEV_PECL     = 2;
  localparam int unsigned   CLKRNG_BIT_CLK_QUIET    = 0;
  localparam int unsigned   CLKRNG_BIT_CORE_QUIET   = 2;
  // full-scale codes and idle read value
  localparam logic [15:0]   CLKRNG_FS_MAX_CODE      = 16'hffff;
  localparam logic [15:0]   CLKRNG_FS_MIN_GOOD_CODE = 16'h2000;
  localparam logic [7:0]    CLKRNG_READ_IDLE        = 8'h00;
endpackage

// >>> clkrng_align_if.sv
`timescale 1ns/1ns
`default_nettype none
interface clkrng_align_if;
  import clkrng_pkg::*;
  logic                     invert;
  logic [CLKRNG_DSEL_W-1:0] delay_sel;
  logic [CLKRNG_POS_W-1:0]  edge_pos;
  logic                     edge_seen;
  modport bank (output invert, output delay_sel,
                input edge_pos, input edge_seen);
  modport capture (input invert, input delay_sel,
                   output edge_pos, output edge_seen);
endinterface
`default_nettype wire

// >>> clkrng_align_capture.sv
`timescale 1ns/1ns
`default_nettype none
module clkrng_align_capture
  import clkrng_pkg::*;
#(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    alignref_i,
  input  wire logic [CLKRNG_POS_W-1:0] edge_window_i,
  clkrng_align_if.capture              aif,
  output logic                         alignref_aligned_o
);
  // ==========================================================
  // polarity and delay line
  logic             ref_pol;
  logic             ref_prev_r;
  logic [DEPTH-1:0] dly_r;

  // R2: optional inversion
  assign ref_pol = alignref_i ^ aif.invert;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      dly_r      <= '0;
      ref_prev_r <= 1'b0;
    end else begin
      dly_r      <= {dly_r[DEPTH-2:0], ref_pol};
      ref_prev_r <= ref_pol;
    end
  end

  // R12: selected capture delay tap
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      alignref_aligned_o <= 1'b0;
    end else begin
      alignref_aligned_o <= dly_r[aif.delay_sel];
    end
  end

  // ==========================================================
  // edge position capture
  // R7: window sampled on rising edge
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      aif.edge_pos  <= CLKRNG_RST_EDGE_POS;
      aif.edge_seen <= 1'b0;
    end else begin
      aif.edge_seen <= ref_pol & ~ref_prev_r;
      if (ref_pol && !ref_prev_r) begin
        aif.edge_pos <= edge_window_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> clkrng_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: software rewrites reserved bits with defaults
// R2: bit 0 at 0x2a inverts alignment reference
// R3: bit 2 selects pecl for device clock
// R4: bit 1 selects pecl for alignment reference
// R5: bit 2 at 0x2b enables core supply quieting
// R6: bit 0 enables clock supply quieting
// R7: read-only 24-bit edge position at 0x2c
// R8: software picks delay from edge position
// R9: 16-bit range at 0x30, resets 0xa000
// R10: software avoids range codes below 0x2000
// R11: code 0xffff is maximum full scale
// R12: 4-bit delay select chooses capture delay
module clkrng_bank
  import clkrng_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic [CLKRNG_ADDR_W-1:0] reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_rd_i,
  output logic [7:0]                    reg_rdata_o,
  output logic                          reg_rvalid_o,
  input  wire logic [CLKRNG_DSEL_W-1:0] alignref_delay_select_i,
  input  wire logic                     alignref_i,
  input  wire logic [CLKRNG_POS_W-1:0]  edge_window_i,
  output logic                          alignref_aligned_o,
  output logic                          devclock_pecl_input_select_o,
  output logic                          alignref_pecl_input_select_o,
  output logic                          core_supply_quiet_enable_o,
  output logic                          clock_supply_quiet_enable_o,
  output logic [CLKRNG_FS_W-1:0]        analog_fullscale_setting_o,
  output logic                          fullscale_at_max_o,
  output logic                          fullscale_below_min_o,
  output logic                          edge_captured_o
);
  // ==========================================================
  // storage
  logic [7:0]              clock_input_control_r;
  logic [7:0]              supply_noise_control_r;
  logic [CLKRNG_FS_W-1:0]  analog_fullscale_setting_r;
  logic [7:0]              rdata_nxt;

  clkrng_align_if aif ();

  function automatic logic hit(input logic [CLKRNG_ADDR_W-1:0] a,
                               input logic [CLKRNG_ADDR_W-1:0] base);
    return a == base;
  endfunction

  // R1: whole byte stored, reserved bits included
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      clock_input_control_r <= CLKRNG_RST_CLK_CTRL;
    end else if (reg_wr_i && hit(reg_addr_i, CLKRNG_OFS_CLK_CTRL)) begin
      clock_input_control_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      supply_noise_control_r <= CLKRNG_RST_SUPPLY;
    end else if (reg_wr_i && hit(reg_addr_i, CLKRNG_OFS_SUPPLY)) begin
      supply_noise_control_r <= reg_wdata_i;
    end
  end

  // R9: range register, low byte at base
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      analog_fullscale_setting_r <= CLKRNG_RST_FULLSCALE;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, CLKRNG_OFS_FULLSCALE)) begin
        analog_fullscale_setting_r[7:0] <= reg_wdata_i;
      end
      if (hit(reg_addr_i, CLKRNG_OFS_FULLSCALE + 15'h0001)) begin
        analog_fullscale_setting_r[15:8] <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // read path
  // R7: edge position readable, writes ignored
  always_comb begin
    rdata_nxt = CLKRNG_READ_IDLE;
    if (hit(reg_addr_i, CLKRNG_OFS_CLK_CTRL)) begin
      rdata_nxt = clock_input_control_r;
    end else if (hit(reg_addr_i, CLKRNG_OFS_SUPPLY)) begin
      rdata_nxt = supply_noise_control_r;
    end else if (hit(reg_addr_i, CLKRNG_OFS_EDGE_POS)) begin
      rdata_nxt = aif.edge_pos[7:0];
    end else if (hit(reg_addr_i, CLKRNG_OFS_EDGE_POS + 15'h0001)) begin
      rdata_nxt = aif.edge_pos[15:8];
    end else if (hit(reg_addr_i, CLKRNG_OFS_EDGE_POS + 15'h0002)) begin
      rdata_nxt = aif.edge_pos[23:16];
    end else if (hit(reg_addr_i, CLKRNG_OFS_FULLSCALE)) begin
      rdata_nxt = analog_fullscale_setting_r[7:0];
    end else if (hit(reg_addr_i, CLKRNG_OFS_FULLSCALE + 15'h0001)) begin
      rdata_nxt = analog_fullscale_setting_r[15:8];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= CLKRNG_READ_IDLE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // one-cycle answer strobe
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ==========================================================
  // controls out
  // R2: inversion to capture path
  assign aif.invert    = clock_input_control_r[CLKRNG_BIT_INVERT];
  // R12: delay select from outside field
  assign aif.delay_sel = alignref_delay_select_i;

  // R3: device clock pecl select
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      devclock_pecl_input_select_o <=
        CLKRNG_RST_CLK_CTRL[CLKRNG_BIT_DEV_PECL];
    end else begin
      devclock_pecl_input_select_o <=
        clock_input_control_r[CLKRNG_BIT_DEV_PECL];
    end
  end

  // R4: reference pecl select
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      alignref_pecl_input_select_o <=
        CLKRNG_RST_CLK_CTRL[CLKRNG_BIT_REF_PECL];
    end else begin
      alignref_pecl_input_select_o <=
        clock_input_control_r[CLKRNG_BIT_REF_PECL];
    end
  end

  // R5: core supply quieting
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      core_supply_quiet_enable_o <=
        CLKRNG_RST_SUPPLY[CLKRNG_BIT_CORE_QUIET];
    end else begin
      core_supply_quiet_enable_o <=
        supply_noise_control_r[CLKRNG_BIT_CORE_QUIET];
    end
  end

  // R6: clock supply quieting
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      clock_supply_quiet_enable_o <=
        CLKRNG_RST_SUPPLY[CLKRNG_BIT_CLK_QUIET];
    end else begin
      clock_supply_quiet_enable_o <=
        supply_noise_control_r[CLKRNG_BIT_CLK_QUIET];
    end
  end

  // range code to the analog front end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      analog_fullscale_setting_o <= CLKRNG_RST_FULLSCALE;
    end else begin
      analog_fullscale_setting_o <= analog_fullscale_setting_r;
    end
  end

  // R11: maximum full-scale code
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fullscale_at_max_o <= CLKRNG_RST_FULLSCALE == CLKRNG_FS_MAX_CODE;
    end else begin
      fullscale_at_max_o <=
        analog_fullscale_setting_r == CLKRNG_FS_MAX_CODE;
    end
  end

  // R10: flags degraded range codes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fullscale_below_min_o <=
        CLKRNG_RST_FULLSCALE < CLKRNG_FS_MIN_GOOD_CODE;
    end else begin
      fullscale_below_min_o <=
        analog_fullscale_setting_r < CLKRNG_FS_MIN_GOOD_CODE;
    end
  end

  // capture strobe, one cycle after the latch
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      edge_captured_o <= 1'b0;
    end else begin
      edge_captured_o <= aif.edge_seen;
    end
  end

  clkrng_align_capture #(
    .DEPTH (16)
  ) u_capture (
    .core_clk_i         (core_clk_i),
    .rstn_i             (rstn_i),
    .alignref_i         (alignref_i),
    .edge_window_i      (edge_window_i),
    .aif                (aif.capture),
    .alignref_aligned_o (alignref_aligned_o)
  );
endmodule
`default_nettype wire

// >>> clkrng_bank_properties.sv
`timescale 1ns/1ns
`default_nettype none
module clkrng_bank_chk
  import clkrng_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic [CLKRNG_ADDR_W-1:0] reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [7:0]               reg_rdata_o,
  input  wire logic                     reg_rvalid_o,
  input  wire logic                     devclock_pecl_input_select_o,
  input  wire logic                     alignref_pecl_input_select_o,
  input  wire logic                     core_supply_quiet_enable_o,
  input  wire logic                     clock_supply_quiet_enable_o,
  input  wire logic [CLKRNG_FS_W-1:0]   analog_fullscale_setting_o
);
  // ===========================================
  // write decode
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic w_clk, w_sup, w_lo, w_hi;
  assign w_clk = reg_wr_i && reg_addr_i == CLKRNG_OFS_CLK_CTRL;
  assign w_sup = reg_wr_i && reg_addr_i == CLKRNG_OFS_SUPPLY;
  assign w_lo  = reg_wr_i && reg_addr_i == CLKRNG_OFS_FULLSCALE;
  assign w_hi  = reg_wr_i && reg_addr_i == CLKRNG_OFS_FULLSCALE + 15'h1;
  // ===========================================
  // properties
  a_dev_pecl_sel: assert property (w_clk |-> ##2
    devclock_pecl_input_select_o == $past(reg_wdata_i[2], 2))
    else $error("device clock input select wrong");
  a_ref_pecl_sel: assert property (w_clk |-> ##2
    alignref_pecl_input_select_o == $past(reg_wdata_i[1], 2))
    else $error("reference input select wrong");
  a_core_quiet_en: assert property (w_sup |-> ##2
    core_supply_quiet_enable_o == $past(reg_wdata_i[2], 2))
    else $error("core supply quiet wrong");
  a_clk_quiet_en: assert property (w_sup |-> ##2
    clock_supply_quiet_enable_o == $past(reg_wdata_i[0], 2))
    else $error("clock supply quiet wrong");
  a_fs_low_byte: assert property (w_lo |-> ##2
    analog_fullscale_setting_o[7:0] == $past(reg_wdata_i, 2))
    else $error("full-scale low byte wrong");
  a_fs_high_byte: assert property (w_hi |-> ##2
    analog_fullscale_setting_o[15:8] == $past(reg_wdata_i, 2))
    else $error("full-scale high byte wrong");
  a_fs_read_back: assert property (
    reg_rd_i && reg_addr_i == CLKRNG_OFS_FULLSCALE |=>
    reg_rvalid_o && reg_rdata_o == analog_fullscale_setting_o[7:0])
    else $error("full-scale read wrong");
  a_rdata_hold: assert property (!reg_rd_i |=>
    $stable(reg_rdata_o) && !reg_rvalid_o)
    else $error("read data moved without a read");
endmodule
bind clkrng_bank clkrng_bank_chk clkrng_bank_chk_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .devclock_pecl_input_select_o(devclock_pecl_input_select_o),
  .alignref_pecl_input_select_o(alignref_pecl_input_select_o),
  .core_supply_quiet_enable_o(core_supply_quiet_enable_o),
  .clock_supply_quiet_enable_o(clock_supply_quiet_enable_o),
  .analog_fullscale_setting_o(analog_fullscale_setting_o));
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import clkrng_pkg::*;
;
  logic        clk, rstn, wr, rd, aref;
  logic [14:0] addr;
  logic [7:0]  wd, rdat;
  logic [23:0] win;
  logic [15:0] fs;
  logic [3:0]  dsel;
  logic        rv, algn, devp, refp, corq, clkq, fmax, fmin, cap;
  int          n_mismatch, n_checks;
  logic [14:0] ra [8] = '{15'h2a, 15'h2b, 15'h2c, 15'h2d, 15'h2e, 15'h30,
                          15'h31, 15'h40};
  logic [7:0]  rv0 [8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'ha0, 8'h00};
  clkrng_bank clkrng_bank_inst (.core_clk_i(clk), .rstn_i(rstn),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .alignref_delay_select_i(dsel),
    .alignref_i(aref), .edge_window_i(win), .alignref_aligned_o(algn),
    .devclock_pecl_input_select_o(devp), .alignref_pecl_input_select_o(refp),
    .core_supply_quiet_enable_o(corq), .clock_supply_quiet_enable_o(clkq),
    .analog_fullscale_setting_o(fs), .fullscale_at_max_o(fmax),
    .fullscale_below_min_o(fmin), .edge_captured_o(cap));
  // ===========================================
  // tasks
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wrb(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rdb(input logic [14:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1;
    chk("rvalid", 24'h1, {23'h0, rv});
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, rdat});
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wait_cap;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk); #1;
      if (cap === 1'b1) return;
    end
    n_mismatch++;
    test_done;
  endtask
  // ===========================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, aref} = 4'h0; addr = 15'h0; wd = 8'h0;
    dsel = 4'h0;
    win = 24'h5a3c96; n_mismatch = 0; n_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rdb(ra[i], rv0[i]);
    chk("fs reset", 24'h00a000, {8'h0, fs});
    wrb(15'h2a, 8'h07); wrb(15'h2b, 8'h15);
    wrb(15'h30, 8'hff); wrb(15'h31, 8'hff);
    wrb(15'h2c, 8'hab);
    settle();
    chk("dev pecl", 24'h1, {23'h0, devp});
    chk("ref pecl", 24'h1, {23'h0, refp});
    chk("core quiet", 24'h1, {23'h0, corq});
    chk("clk quiet", 24'h1, {23'h0, clkq});
    chk("fs max", 24'h1, {23'h0, fmax});
    rdb(15'h2b, 8'h15);
    rdb(15'h2c, 8'h96);
    @(posedge clk); aref <= 1'b1;
    settle();
    rdb(15'h2c, 8'h96);
    @(posedge clk); aref <= 1'b0; win <= 24'h123456;
    wait_cap();
    rdb(15'h2c, 8'h56); rdb(15'h2d, 8'h34); rdb(15'h2e, 8'h12);
    chk("aligned", 24'h1, {23'h0, algn});
    rdb(15'h2c, 8'h56);
    @(posedge clk); dsel <= rdat[3:0];
    @(posedge clk); aref <= 1'b1;
    repeat (7) @(posedge clk);
    #1;
    chk("aligned held", 24'h1, {23'h0, algn});
    @(posedge clk); #1;
    chk("aligned delayed", 24'h0, {23'h0, algn});
    wrb(15'h31, 8'h1f);
    settle();
    chk("fs low", 24'h001fff, {8'h0, fs});
    chk("below min", 24'h1, {23'h0, fmin});
    chk("not max", 24'h0, {23'h0, fmax});
    wrb(15'h31, 8'h20); wrb(15'h30, 8'h00);
    wrb(15'h2a, 8'h00);
    wrb(15'h2b, 8'h10);
    settle();
    chk("fs min good", 24'h0, {23'h0, fmin});
    rdb(15'h30, 8'h00); rdb(15'h31, 8'h20);
    chk("dev pecl off", 24'h0, {23'h0, devp});
    chk("ref pecl off", 24'h0, {23'h0, refp});
    chk("core quiet off", 24'h0, {23'h0, corq});
    chk("clk quiet off", 24'h0, {23'h0, clkq});
    test_done();
  end
endmodule
`default_nettype wire
